// ---- dcb_sequencer.sv ----
// dc braking sequencer: decides when and how long to brake
// Operation
// - carrier capped 5 kHz, lowered to 2 kHz
// - select 00 off, 01 on, 02 command
// - brake when output freq at or below onset
// - nonzero delay cuts output before stop or terminal braking
// - force scales braking, zero means none
// - duration zero suppresses all but level terminal braking; edge style timed
// - select 01 method 00 brakes after shutoff
// - edge style brakes full duration despite run
// - level style start ends braking at once
// - select 02 needs command and output low
// - command braking starts only while run asserted
// - command edge style resumes after duration
// - start normal above onset plus 2 Hz
// - command level style resumes above onset+2
// - command braking ignores external brake input
// - command braking forces plain dc method
// - external input brakes with select 00/01
// - terminal delay keeps output off, coasting
// - edge style terminal brakes for duration
// - level style terminal brakes while input on
// - external input beats run and stop
// - external input forces plain dc method
`timescale 1ns/10ps
`include "dcb_defs.svh"

module dcb_sequencer
   import dcb_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        run_cmd,
   input  wire logic        ext_brake_input,
   input  wire logic [15:0] freq_command,
   input  wire logic [15:0] output_frequency,
   input  wire dcb_cfg_t    cfg,
   output dcb_out_t         drive_out
);

   // two-flop synchronisers for pin inputs
   logic [1:0] run_sync_reg;
   logic [1:0] run_sync_next;
   logic [1:0] ext_sync_reg;
   logic [1:0] ext_sync_next;

   // shift the raw pins in; only bit 1 feeds the logic
   always_comb begin
      run_sync_next = {run_sync_reg[0], run_cmd};
      ext_sync_next = {ext_sync_reg[0], ext_brake_input};
   end

   // synchroniser registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         run_sync_reg <= 2'h0;
         ext_sync_reg <= 2'h0;
      end else begin
         run_sync_reg <= run_sync_next;
         ext_sync_reg <= ext_sync_next;
      end
   end
   logic run_s;
   logic ext_s;
   assign run_s = run_sync_reg[1];
   assign ext_s = ext_sync_reg[1];

   // saturating 10 ms counter decrement
   function automatic logic [15:0] dec_sat(input logic [15:0] v);
      dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
   endfunction

   // frequency at or below a limit, both in 0.01 Hz
   function automatic logic at_or_below(input logic [15:0] f,
                                        input logic [15:0] lim);
      at_or_below = (f <= lim);
   endfunction

   // 10 ms tick prescaler
   localparam logic [21:0] TICK_LAST = 22'(`DCB_TICK_CYC - 1);
   logic [21:0] tick_cnt_reg;
   logic [21:0] tick_cnt_next;
   logic        tick;
   always_comb begin
      tick          = (tick_cnt_reg == TICK_LAST);
      tick_cnt_next = tick ? 22'h0 : tick_cnt_reg + 22'h1;
   end

   // prescaler register; free running so ticks stay 10 ms apart
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tick_cnt_reg <= 22'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // trigger conditions
   logic        fcmd_mode;
   logic        enabled;
   logic        ext_mode;
   logic        out_low;
   logic        cmd_low;
   logic        cmd_high;
   logic [16:0] onset_hyst;
   logic        force_set;
   logic        dur_set;
   always_comb begin
      fcmd_mode  = (cfg.braking_select == `DCB_SEL_FCMD);
      // zero force or zero duration blocks stop and command braking
      force_set  = (cfg.brake_force != 7'h00);
      dur_set    = (cfg.brake_duration != 16'h0000);
      enabled    = force_set && dur_set;
      ext_mode   = !fcmd_mode && ext_s;
      out_low    = at_or_below(output_frequency,
                               cfg.brake_onset_frequency);
      cmd_low    = at_or_below(freq_command, cfg.brake_onset_frequency);
      onset_hyst = {1'b0, cfg.brake_onset_frequency} +
                   {1'b0, `DCB_HYST_CHZ};
      cmd_high   = ({1'b0, freq_command} > onset_hyst);
   end

   // sequencer state
   //    run:   normal drive, triggers watched
   //    delay: output cut, motor coasts, delay timer runs
   //    brake: dc current applied, duration timer runs
   // the timer is shared; each delay or brake entry reloads it
   dcb_state_t  state_reg;
   dcb_state_t  state_next;
   logic [15:0] timer_reg;
   logic [15:0] timer_next;
   logic        run_d_reg;
   logic        ext_d_reg;
   logic        by_ext_reg;
   logic        by_ext_next;
   logic        stop_trig;
   logic        fcmd_trig;
   logic        ext_rise;
   logic        edge_st;
   logic        ext_trig;
   logic        stop_pend_reg;
   logic        stop_pend_next;
   logic        stop_taken;
   always_comb begin
      state_next  = state_reg;
      timer_next  = timer_reg;
      by_ext_next = by_ext_reg;
      edge_st     = (cfg.trigger_style_select == `DCB_STYLE_EDGE);
      ext_rise    = ext_mode && !ext_d_reg;
      // edge-style terminal needs a nonzero duration
      ext_trig    = (edge_st ? (ext_rise && dur_set) : ext_mode) &&
                    force_set;
      // stop braking after run removal, select 01
      stop_trig   = (cfg.braking_select == `DCB_SEL_ON) && !run_s &&
                    (run_d_reg || stop_pend_reg) && out_low &&
                    enabled;
      // command braking only while run on
      fcmd_trig   = fcmd_mode && run_s && cmd_low && out_low && enabled;
      if (tick && timer_reg != 16'h0000) begin
         timer_next = dec_sat(timer_reg);
      end
      case (state_reg)
         DCB_RUN: begin
            // terminal takes precedence over run and stop
            if (ext_trig) begin
               by_ext_next = 1'b1;
               if (cfg.brake_delay_time != 16'h0000) begin
                  state_next = DCB_DELAY;
                  timer_next = cfg.brake_delay_time;
               end else begin
                  state_next = DCB_BRAKE;
                  timer_next = cfg.brake_duration;
               end
            end else if (stop_trig || fcmd_trig) begin
               by_ext_next = 1'b0;
               if (stop_trig && cfg.brake_delay_time != 16'h0000) begin
                  state_next = DCB_DELAY;
                  timer_next = cfg.brake_delay_time;
               end else begin
                  state_next = DCB_BRAKE;
                  timer_next = cfg.brake_duration;
               end
            end
         end
         DCB_DELAY: begin
            if (by_ext_reg && !edge_st && !ext_mode) begin
               state_next = DCB_RUN;
            end else if (!by_ext_reg && !edge_st && run_s) begin
               state_next = DCB_RUN;
            end else if (timer_reg == 16'h0000) begin
               state_next = DCB_BRAKE;
               timer_next = cfg.brake_duration;
            end
         end
         default: begin
            if (edge_st) begin
               // full duration regardless of run
               if (timer_reg == 16'h0000) begin
                  state_next = DCB_RUN;
               end
            end else if (by_ext_reg) begin
               if (!ext_mode) begin
                  state_next = DCB_RUN;
               end
            end else if (fcmd_mode) begin
               if (cmd_high || !run_s) begin
                  state_next = DCB_RUN;
               end
            end else if (run_s) begin
               state_next = DCB_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg    <= DCB_RUN;
         timer_reg    <= 16'h0000;
         by_ext_reg   <= 1'b0;
      end else begin
         state_reg    <= state_next;
         timer_reg    <= timer_next;
         by_ext_reg   <= by_ext_next;
      end
   end

   // edge history of the synced run and terminal levels
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         run_d_reg <= 1'b0;
         ext_d_reg <= 1'b0;
      end else begin
         run_d_reg <= run_s;
         ext_d_reg <= ext_mode;
      end
   end

   // any departure from run consumes a pending stop
   assign stop_taken = (state_reg == DCB_RUN) && (state_next != DCB_RUN);

   // stop pending: run removed while the output is still falling;
   // without it the stop would be missed, since the frequency is
   // nearly always above onset at the moment run drops
   always_comb begin
      if (run_s) begin
         stop_pend_next = 1'b0;                 // new run cancels stop
      end else if (stop_taken) begin
         stop_pend_next = 1'b0;                 // one brake per stop
      end else if (run_d_reg) begin
         stop_pend_next = 1'b1;                 // run just removed
      end else begin
         stop_pend_next = stop_pend_reg;
      end
   end

   // stop pending register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stop_pend_reg <= 1'b0;
      end else begin
         stop_pend_reg <= stop_pend_next;
      end
   end

   // registered outputs to the power stage
   dcb_out_t out_next;
   dcb_out_t out_reg;
   logic [6:0] carrier_cap;
   always_comb begin
      carrier_cap = (cfg.carrier_setting > `DCB_CARRIER_MAX) ?
                    `DCB_CARRIER_MAX : cfg.carrier_setting;
      out_next.brake_req   = (state_reg == DCB_BRAKE);
      out_next.output_off  = (state_reg != DCB_RUN);
      out_next.brake_level = (state_reg == DCB_BRAKE) ?
                             cfg.brake_force : 7'h00;
      if (state_reg == DCB_RUN) begin
         out_next.carrier_out = cfg.carrier_setting;
      end else if (cfg.brake_force > `DCB_FORCE_HI) begin
         out_next.carrier_out = `DCB_CARRIER_MIN;
      end else begin
         out_next.carrier_out = carrier_cap;
      end
      // plain dc for terminal or command braking
      out_next.method_eff  = (by_ext_reg || fcmd_mode) ?
                             `DCB_METHOD_DC : cfg.brake_method_select;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end
   assign drive_out = out_reg;

endmodule

// ---- dcb_defs.svh ----
// constants for the dc braking sequencer
`ifndef DCB_DEFS_SVH
`define DCB_DEFS_SVH
`define DCB_CLK_HZ        250000000
`define DCB_TICK_MS       10
`define DCB_TICK_CYC      ((`DCB_CLK_HZ / 1000) * `DCB_TICK_MS)
`define DCB_SEL_OFF       2'h0
`define DCB_SEL_ON        2'h1
`define DCB_SEL_FCMD      2'h2
`define DCB_STYLE_EDGE    1'h0
`define DCB_STYLE_LEVEL   1'h1
`define DCB_METHOD_DC     2'h0
`define DCB_FREQ_MAX      16'hE678
`define DCB_HYST_CHZ      16'h00C8
`define DCB_DELAY_MAX     16'h01F4
`define DCB_DUR_MAX       16'h1770
`define DCB_FORCE_MAX     7'h64
`define DCB_CARRIER_MAX   7'h32
`define DCB_CARRIER_MIN   7'h14
`define DCB_FORCE_HI      7'h32
`endif

// ---- dcb_pkg.sv ----
// types for the dc braking sequencer
package dcb_pkg;
   typedef enum logic [1:0] {
      DCB_RUN   = 2'b00,
      DCB_DELAY = 2'b01,
      DCB_BRAKE = 2'b10
   } dcb_state_t;

   typedef struct packed {
      logic [1:0]  braking_select;
      logic [1:0]  brake_method_select;
      logic [15:0] brake_onset_frequency;
      logic [15:0] brake_delay_time;
      logic [6:0]  brake_force;
      logic [15:0] brake_duration;
      logic        trigger_style_select;
      logic [6:0]  carrier_setting;
   } dcb_cfg_t;

   typedef struct packed {
      logic        brake_req;
      logic        output_off;
      logic [6:0]  brake_level;
      logic [6:0]  carrier_out;
      logic [1:0]  method_eff;
   } dcb_out_t;
endpackage

// ---- dcb_power_stage.sv ----
// behavioural power stage: output frequency follows the drive
`timescale 1ns/10ps
module dcb_power_stage
   import dcb_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        run_cmd,
   input  wire logic [15:0] freq_command,
   input  wire dcb_out_t    drive_out,
   output logic [15:0]      output_frequency
);
   logic [15:0] tgt;
   initial output_frequency = 16'h0000;
   assign tgt = run_cmd ? freq_command : 16'h0000;
   // ramp toward target; no output while shut off
   always @(posedge clk_sys) begin
      if (drive_out.output_off)
         output_frequency <= 16'h0000;
      else if (output_frequency + 16'h0400 < tgt)
         output_frequency <= output_frequency + 16'h0400;
      else if (output_frequency > tgt + 16'h0400)
         output_frequency <= output_frequency - 16'h0400;
      else
         output_frequency <= tgt;
   end
endmodule

// ---- dcb_sequencer_monitor.sv ----
// port assertions for the dc braking sequencer
`timescale 1ns/10ps
module dcb_sequencer_monitor
   import dcb_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        run_cmd,
   input wire logic        ext_brake_input,
   input wire logic [15:0] freq_command,
   input wire logic [15:0] output_frequency,
   input wire dcb_cfg_t    cfg,
   input wire dcb_out_t    drive_out
);
   dcb_out_t o;
   assign o = drive_out;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // terminal turned on with braking allowed
   sequence ext_on_s;
      $rose(ext_brake_input) && cfg.braking_select != 2'h2 &&
      cfg.brake_force != 7'h00 && cfg.brake_delay_time == 16'h0000 &&
      (cfg.trigger_style_select || cfg.brake_duration != 16'h0000);
   endsequence
   sequence run_low_s;
      !run_cmd [*6];
   endsequence
   sequence lvl_start_s;
      $rose(run_cmd) && cfg.trigger_style_select &&
      cfg.braking_select == 2'h1 && !ext_brake_input;
   endsequence
   ext_brake_a: assert property (ext_on_s |-> ##[1:6] o.brake_req)
      else $error("terminal did not start braking");
   fcmd_run_a: assert property ((cfg.braking_select == 2'h2)
      ##0 run_low_s |-> !o.brake_req) else $error("command brake idle run");
   level_stop_a: assert property (lvl_start_s |-> ##[1:6] !o.brake_req)
      else $error("start did not end level braking");
   level_force_a: assert property (o.brake_level ==
      (o.brake_req ? cfg.brake_force : 7'h00)) else $error("brake level wrong");
   brake_off_a: assert property (o.brake_req |-> o.output_off)
      else $error("braking with output on");
   carrier_cap_a: assert property (o.brake_req && cfg.brake_force <= 7'h32
      |-> o.carrier_out == (cfg.carrier_setting > 7'h32 ? 7'h32 :
      cfg.carrier_setting)) else $error("carrier not capped");
   carrier_low_a: assert property (o.brake_req && cfg.brake_force > 7'h32
      |-> o.carrier_out == 7'h14) else $error("carrier not lowered");
   method_dc_a: assert property (o.brake_req && cfg.braking_select != 2'h1
      |-> o.method_eff == 2'h0) else $error("method not plain dc");
endmodule
bind dcb_sequencer dcb_sequencer_monitor dcb_sequencer_monitor_i (
   .clk_sys(clk_sys), .rst(rst), .run_cmd(run_cmd),
   .ext_brake_input(ext_brake_input), .freq_command(freq_command),
   .output_frequency(output_frequency), .cfg(cfg), .drive_out(drive_out));

// ---- dcb_sequencer_tb.sv ----
// self-checking testbench for the dc braking sequencer
`timescale 1ns/10ps
module dcb_sequencer_tb;
   import dcb_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        run_cmd = 1'b0;
   logic        ext_brake_input = 1'b0;
   logic [15:0] freq_command = 16'h0000;
   logic [15:0] output_frequency;
   dcb_cfg_t    cfg = '0;
   dcb_out_t    drive_out;
   logic        smp = 1'b0;
   logic [31:0] seed = 32'h00014032;
   logic [8:0]  e;
   logic [8:0]  q[$];
   int          errors = 0;
   int          compares = 0;
   always #2 clk_sys = ~clk_sys;
   dcb_sequencer dcb_sequencer_i (.clk_sys(clk_sys), .rst(rst),
      .run_cmd(run_cmd), .ext_brake_input(ext_brake_input),
      .freq_command(freq_command), .output_frequency(output_frequency),
      .cfg(cfg), .drive_out(drive_out));
   dcb_power_stage dcb_power_stage_i (.clk_sys(clk_sys), .run_cmd(run_cmd),
      .freq_command(freq_command), .drive_out(drive_out),
      .output_frequency(output_frequency));
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic give_verdict;
      if (errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // reset, then load a config with random force and carrier
   task automatic setup(logic [1:0] s, logic t, logic [15:0] d, logic [15:0] u);
      rst = 1'b1;
      run_cmd = 1'b0;
      ext_brake_input = 1'b0;
      freq_command = 16'h0000;
      seed = xs(seed);
      cfg = '{s, (s == 2'h1) ? 2'h0 : seed[9:8], 16'h1000, d,
              7'(seed % 100) + 7'h01, u, t, seed[6:0]};
      cyc(6);
      rst = 1'b0;
      cyc(2);
   endtask
   // note the expected outputs, then strobe the watcher
   task automatic expect_out(logic b, logic f);
      cyc(40);
      q.push_back({b, f, b ? cfg.brake_force : 7'h00});
      smp = 1'b1;
      cyc(1);
      smp = 1'b0;
   endtask
   // watcher takes the oldest note at each strobe
   always @(posedge clk_sys) begin
      if (smp) begin
         e = q.pop_front();
         compares++;
         if ({drive_out.brake_req, drive_out.output_off,
              drive_out.brake_level} !== e) begin
            errors++;
            $display("CHECK FAILED drive_out exp %h got %h", e,
               {drive_out.brake_req, drive_out.output_off,
                drive_out.brake_level});
         end
      end
   end
   initial begin
      setup(2'h0, 1'h1, 16'h0000, 16'h0001);
      ext_brake_input = 1'b1;
      expect_out(1'b1, 1'b1);
      ext_brake_input = 1'b0;
      expect_out(1'b0, 1'b0);
      setup(2'h1, 1'h0, 16'h0000, 16'h0001);
      run_cmd = 1'b1;
      freq_command = 16'h3000;
      ext_brake_input = 1'b1;
      expect_out(1'b1, 1'b1);
      setup(2'h2, 1'h1, 16'h0000, 16'h0001);
      ext_brake_input = 1'b1;
      expect_out(1'b0, 1'b0);
      setup(2'h1, 1'h1, 16'h0000, 16'h0001);
      run_cmd = 1'b1;
      freq_command = 16'h3000;
      cyc(40);
      run_cmd = 1'b0;
      expect_out(1'b1, 1'b1);
      run_cmd = 1'b1;
      expect_out(1'b0, 1'b0);
      setup(2'h1, 1'h1, 16'h0000, 16'h0000);
      run_cmd = 1'b1;
      cyc(20);
      run_cmd = 1'b0;
      expect_out(1'b0, 1'b0);
      setup(2'h0, 1'h1, 16'h0000, 16'h0001);
      cfg.brake_force = 7'h00;
      ext_brake_input = 1'b1;
      expect_out(1'b0, 1'b0);
      setup(2'h2, 1'h1, 16'h0000, 16'h0001);
      freq_command = 16'h3000;
      run_cmd = 1'b1;
      expect_out(1'b0, 1'b0);
      freq_command = 16'h0000;
      expect_out(1'b1, 1'b1);
      freq_command = 16'h10D8;
      expect_out(1'b0, 1'b0);
      setup(2'h0, 1'h1, 16'h0001, 16'h0001);
      ext_brake_input = 1'b1;
      expect_out(1'b0, 1'b1);
      setup(2'h1, 1'h1, 16'h0001, 16'h0001);
      run_cmd = 1'b1;
      cyc(20);
      run_cmd = 1'b0;
      expect_out(1'b0, 1'b1);
      give_verdict();
   end
   // hang guard
   initial begin
      #200000;
      errors++;
      give_verdict();
   end
endmodule
